// ### rtl/multi_counter_timing_unit_pkg.sv
// Constants for the five-channel counter/timer unit.
// Assumes a 40 MHz system clock and an APB register bus.
package multi_counter_timing_unit_pkg;
	// ****************************************
	// Clocking
	// ****************************************
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int MASTER_CLK_HZ = 10_000_000;
	localparam int MASTER_DIV = SYS_CLK_HZ / MASTER_CLK_HZ;
	localparam int PRESCALE = 10;
	localparam logic [1:0] MASTER_DIV_LAST = 2'(MASTER_DIV - 1);
	localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE - 1);
	localparam logic [3:0] DECADE_LAST = 4'h9;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] GLOBAL_BLOCK = 4'h5;
	localparam logic [1:0] CTR_MODE_WORD = 2'h0;
	localparam logic [1:0] CTR_HOLD_WORD = 2'h1;
	localparam logic [1:0] CTR_COUNT_WORD = 2'h2;
	localparam logic [1:0] CTR_CMD_WORD = 2'h3;
	localparam logic [1:0] FREQ_WORD = 2'h0;
	localparam logic [1:0] BOARD_WORD = 2'h1;
	localparam logic [1:0] ACQ_CLEAR_WORD = 2'h2;
	localparam logic [1:0] STATUS_WORD = 2'h3;
	// ****************************************
	// Field layouts
	// ****************************************
	localparam int MODE_SRC_LSB = 0;
	localparam int MODE_FALL_BIT = 4;
	localparam int MODE_GATE_LSB = 5;
	localparam int MODE_DOWN_BIT = 8;
	localparam int MODE_RELOAD_BIT = 9;
	localparam int MODE_TOGGLE_BIT = 10;
	localparam int MODE_INVERT_BIT = 11;
	localparam int MODE_OUT_LSB = 12;
	localparam logic [2:0] GATE_NONE = 3'h0;
	localparam logic [2:0] GATE_HIGH = 3'h1;
	localparam logic [2:0] GATE_LOW = 3'h2;
	localparam logic [2:0] GATE_RISE = 3'h3;
	localparam logic [2:0] GATE_FALL = 3'h4;
	localparam logic [2:0] GATE_NEXT_HIGH = 3'h5;
	localparam logic [2:0] GATE_PREV_HIGH = 3'h6;
	localparam logic [1:0] OUT_ACTIVE = 2'h0;
	localparam logic [1:0] OUT_HIZ = 2'h1;
	localparam logic [1:0] OUT_LOW = 2'h2;
	localparam int CMD_ARM_BIT = 0;
	localparam int CMD_DISARM_BIT = 1;
	localparam int CMD_LOAD_BIT = 2;
	localparam int FREQ_SRC_LSB = 0;
	localparam int FREQ_DIV_LSB = 4;
	localparam int FREQ_EN_BIT = 8;
	localparam logic [3:0] FREQ_SRC_LAST = 4'hE;
	localparam int BOARD_LINE_LSB = 0;
	localparam int BOARD_IRQ_EN_BIT = 3;
	localparam int BOARD_DEFER_BIT = 4;
	localparam int BOARD_CHAIN_BIT = 5;
	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [15:0] MODE_RESET = 16'h1000;
	localparam logic [15:0] HOLD_RESET = 16'h0000;
	localparam logic [8:0] FREQ_RESET = 9'h000;
	localparam logic [5:0] BOARD_RESET = 6'h00;
	// Pulled-up pins idle high; reset there so release shows no false edge
	localparam logic [12:0] SYNC_IDLE = 13'h07FF;
	localparam logic [4:0] GATE_IDLE = 5'h13;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;
	localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
endpackage

// ### rtl/multi_counter_timing_unit.sv
// Five 16-bit counters, timebases, divided frequency output and trigger glue.
// Assumes an APB master on sys_clk_in and field pins asynchronous to it.
`timescale 1ns/1ps
`default_nettype none
module multi_counter_timing_unit (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output var logic [31:0] prdata_out,
	output var logic pready_out,
	output var logic pslverr_out,
	input wire logic board_master_clock_in,
	input wire logic clock_select_jumper_in,
	input wire logic [4:0] gate_pin_in,
	input wire logic [4:0] source_pin_in,
	input wire logic stop_trigger_input_in,
	input wire logic [6:0] trigger_crossbar_bus_in,
	input wire logic scan_step_clock_in,
	input wire logic acq_third_gate_in,
	input wire logic sample_count_done_in,
	input wire logic acq_overflow_in,
	input wire logic acq_overrun_in,
	output var logic [4:0] counter_out_out,
	output var logic [4:0] counter_oe_out,
	output var logic divided_frequency_output_out,
	output var logic third_counter_output_out,
	output var logic fourth_counter_output_out,
	output var logic second_counter_output_out,
	output var logic fourth_counter_gate_out,
	output var logic dac_update_out,
	output var logic counter_irq_req_out
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [12:0] raw;
	logic [12:0] sync1;
	logic [12:0] sync2;
	logic [12:0] sync3;
	logic [12:0] lv;
	logic [12:0] lv_prev;
	logic [6:0] board_q;
	// Line mux ahead of the synchroniser; a glitch on select costs one edge
	assign raw = {clock_select_jumper_in, board_master_clock_in, stop_trigger_input_in, gate_pin_in,
		trigger_crossbar_bus_in[board_q[multi_counter_timing_unit_pkg::BOARD_LINE_LSB +: 3] % 7],
		source_pin_in[3], scan_step_clock_in, source_pin_in[1:0]};
	genvar b;
	generate
		for (b = 0; b < 13; b++)
		begin : g_sync
			always_ff @(posedge sys_clk_in)
			begin
				if (!nrst_in)
				begin
					sync1[b] <= multi_counter_timing_unit_pkg::SYNC_IDLE[b];
					sync2[b] <= multi_counter_timing_unit_pkg::SYNC_IDLE[b];
					sync3[b] <= multi_counter_timing_unit_pkg::SYNC_IDLE[b];
					lv[b] <= multi_counter_timing_unit_pkg::SYNC_IDLE[b];
					lv_prev[b] <= multi_counter_timing_unit_pkg::SYNC_IDLE[b];
				end
				else
				begin
					sync1[b] <= raw[b];
					sync2[b] <= sync1[b];
					sync3[b] <= sync2[b];
					if (sync2[b] == sync3[b])
						lv[b] <= sync3[b];
					lv_prev[b] <= lv[b];
				end
			end
		end
	endgenerate
	// ****************************************
	// Master clock, prescaler and timebases
	// ****************************************
	logic [1:0] int_cnt;
	logic [3:0] pre_cnt;
	logic [3:0] dec_cnt [1:4];
	logic int_tick;
	logic mtick;
	logic [4:0] tb_ev;
	assign int_tick = (int_cnt == multi_counter_timing_unit_pkg::MASTER_DIV_LAST);
	assign mtick = lv[12] ? (lv[11] & ~lv_prev[11]) : int_tick;
	assign tb_ev[0] = mtick && (pre_cnt == multi_counter_timing_unit_pkg::PRESCALE_LAST);
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			int_cnt <= 2'h0;
			pre_cnt <= 4'h0;
		end
		else
		begin
			int_cnt <= int_tick ? 2'h0 : 2'(int_cnt + 2'h1);
			if (mtick)
				pre_cnt <= tb_ev[0] ? 4'h0 : 4'(pre_cnt + 4'h1);
		end
	end
	genvar k;
	generate
		for (k = 1; k < 5; k++)
		begin : g_decade
			assign tb_ev[k] = tb_ev[k-1] && (dec_cnt[k] == multi_counter_timing_unit_pkg::DECADE_LAST);
			always_ff @(posedge sys_clk_in)
			begin
				if (!nrst_in)
					dec_cnt[k] <= 4'h0;
				else if (tb_ev[k-1])
					dec_cnt[k] <= tb_ev[k] ? 4'h0 : 4'(dec_cnt[k] + 4'h1);
			end
		end
	endgenerate
	// ****************************************
	// Gates, edges and the stop-trigger flip-flop
	// ****************************************
	logic fourth_counter_gate_q;
	logic [4:0] gate_lv;
	logic [4:0] gate_prev;
	logic [4:0] gate_rise;
	logic [4:0] gate_fall;
	logic [4:0] src_rise;
	logic [4:0] src_fall;
	logic stop_rise;
	logic acq_clear_wr;
	assign gate_lv = {lv[9], fourth_counter_gate_q, acq_third_gate_in, lv[6:5]};
	assign gate_rise = gate_lv & ~gate_prev;
	assign gate_fall = ~gate_lv & gate_prev;
	assign src_rise = lv[4:0] & ~lv_prev[4:0];
	assign src_fall = ~lv[4:0] & lv_prev[4:0];
	assign stop_rise = lv[10] & ~lv_prev[10];
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			gate_prev <= multi_counter_timing_unit_pkg::GATE_IDLE;
			fourth_counter_gate_q <= 1'b0;
		end
		else
		begin
			gate_prev <= gate_lv;
			// Set wins so a trigger in the clearing cycle is kept
			if (stop_rise)
				fourth_counter_gate_q <= 1'b1;
			else if (sample_count_done_in || acq_overflow_in || acq_overrun_in || acq_clear_wr)
				fourth_counter_gate_q <= 1'b0;
		end
	end
	// ****************************************
	// APB decode
	// ****************************************
	logic wr_en;
	logic is_global;
	logic [31:0] rd_data;
	logic rd_err;
	logic [8:0] freq_q;
	logic [15:0] mode_q [0:4];
	logic [15:0] hold_q [0:4];
	logic [15:0] count_q [0:4];
	logic [4:0] armed;
	logic [4:0] out_true;
	logic [4:0] out_lg;
	logic [4:0] out_prev;
	logic divided_frequency_output_q;
	assign wr_en = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
	assign is_global = (paddr_in[7:4] == multi_counter_timing_unit_pkg::GLOBAL_BLOCK);
	assign acq_clear_wr = wr_en && is_global && (paddr_in[3:2] == multi_counter_timing_unit_pkg::ACQ_CLEAR_WORD);
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr_in[7:4] < multi_counter_timing_unit_pkg::GLOBAL_BLOCK)
		begin
			case (paddr_in[3:2])
				multi_counter_timing_unit_pkg::CTR_MODE_WORD: rd_data = {16'h0000, mode_q[paddr_in[6:4]]};
				multi_counter_timing_unit_pkg::CTR_HOLD_WORD: rd_data = {16'h0000, hold_q[paddr_in[6:4]]};
				multi_counter_timing_unit_pkg::CTR_COUNT_WORD: rd_data = {16'h0000, count_q[paddr_in[6:4]]};
				default: rd_data = {31'h0000_0000, armed[paddr_in[6:4]]};
			endcase
		end
		else if (is_global)
		begin
			case (paddr_in[3:2])
				multi_counter_timing_unit_pkg::FREQ_WORD: rd_data = {23'h00_0000, freq_q};
				multi_counter_timing_unit_pkg::BOARD_WORD: rd_data = {25'h000_0000, board_q};
				multi_counter_timing_unit_pkg::STATUS_WORD: rd_data = {25'h000_0000, divided_frequency_output_q, out_lg, fourth_counter_gate_q};
				default: rd_data = 32'h0000_0000;
			endcase
		end
		else
			rd_err = 1'b1;
	end
	// No wait state: answer is prepared in setup, completes on first access edge
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end
		else if (psel_in && !penable_in && !pready_out)
		begin
			pready_out <= 1'b1;
			pslverr_out <= rd_err;
			prdata_out <= pwrite_in ? 32'h0000_0000 : rd_data;
		end
		else
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			freq_q <= multi_counter_timing_unit_pkg::FREQ_RESET;
			board_q <= {1'b0, multi_counter_timing_unit_pkg::BOARD_RESET};
		end
		else if (wr_en && is_global && paddr_in[3:2] == multi_counter_timing_unit_pkg::FREQ_WORD)
			freq_q <= pwdata_in[8:0];
		else if (wr_en && is_global && paddr_in[3:2] == multi_counter_timing_unit_pkg::BOARD_WORD)
			board_q <= {1'b0, pwdata_in[5:0]};
	end
	// ****************************************
	// Counters
	// ****************************************
	wire [4:0] cnt_ev;
	wire [4:0] tc_ev;
	logic [4:0] out_rise;
	logic [4:0] out_fall;
	assign out_rise = out_lg & ~out_prev;
	assign out_fall = ~out_lg & out_prev;
	genvar n;
	generate
		for (n = 0; n < 5; n++)
		begin : g_ctr
			logic [3:0] sel;
			logic [2:0] gmode;
			logic [15:0] rise_v;
			logic [15:0] fall_v;
			logic ev;
			logic gate_ok;
			logic started;
			logic down;
			logic at_tc;
			logic wr_here;
			logic [15:0] stepped;
			assign sel = mode_q[n][multi_counter_timing_unit_pkg::MODE_SRC_LSB +: 4];
			assign gmode = mode_q[n][multi_counter_timing_unit_pkg::MODE_GATE_LSB +: 3];
			assign down = mode_q[n][multi_counter_timing_unit_pkg::MODE_DOWN_BIT];
			assign rise_v = {out_rise[(n+4)%5], src_rise, gate_rise, tb_ev};
			assign fall_v = {out_fall[(n+4)%5], src_fall, gate_fall, tb_ev};
			if (n == 4)
			begin : g_chain
				// Chained counter five steps on counter four rollover
				assign ev = board_q[multi_counter_timing_unit_pkg::BOARD_CHAIN_BIT] ? tc_ev[3] :
					(mode_q[n][multi_counter_timing_unit_pkg::MODE_FALL_BIT] ? fall_v[sel] : rise_v[sel]);
			end
			else
			begin : g_plain
				assign ev = mode_q[n][multi_counter_timing_unit_pkg::MODE_FALL_BIT] ? fall_v[sel] : rise_v[sel];
			end
			always_comb
			begin
				case (gmode)
					multi_counter_timing_unit_pkg::GATE_NONE: gate_ok = 1'b1;
					multi_counter_timing_unit_pkg::GATE_HIGH: gate_ok = gate_lv[n];
					multi_counter_timing_unit_pkg::GATE_LOW: gate_ok = ~gate_lv[n];
					multi_counter_timing_unit_pkg::GATE_RISE: gate_ok = started;
					multi_counter_timing_unit_pkg::GATE_FALL: gate_ok = started;
					multi_counter_timing_unit_pkg::GATE_NEXT_HIGH: gate_ok = gate_lv[(n+1)%5];
					multi_counter_timing_unit_pkg::GATE_PREV_HIGH: gate_ok = gate_lv[(n+4)%5];
					default: gate_ok = 1'b0;
				endcase
			end
			assign cnt_ev[n] = armed[n] && ev && gate_ok;
			assign at_tc = down ? (count_q[n] == multi_counter_timing_unit_pkg::COUNT_BOTTOM)
				: (count_q[n] == multi_counter_timing_unit_pkg::COUNT_TOP);
			assign tc_ev[n] = cnt_ev[n] && at_tc;
			assign stepped = down ? 16'(count_q[n] - 16'h0001) : 16'(count_q[n] + 16'h0001);
			assign wr_here = wr_en && (paddr_in[7:4] == 4'(n));
			always_ff @(posedge sys_clk_in)
			begin
				if (!nrst_in)
				begin
					mode_q[n] <= multi_counter_timing_unit_pkg::MODE_RESET;
					hold_q[n] <= multi_counter_timing_unit_pkg::HOLD_RESET;
				end
				else if (wr_here && paddr_in[3:2] == multi_counter_timing_unit_pkg::CTR_MODE_WORD)
					mode_q[n] <= pwdata_in[15:0];
				else if (wr_here && paddr_in[3:2] == multi_counter_timing_unit_pkg::CTR_HOLD_WORD)
					hold_q[n] <= pwdata_in[15:0];
			end
			always_ff @(posedge sys_clk_in)
			begin
				if (!nrst_in)
				begin
					armed[n] <= 1'b0;
					started <= 1'b0;
				end
				else if (wr_here && paddr_in[3:2] == multi_counter_timing_unit_pkg::CTR_CMD_WORD
					&& pwdata_in[multi_counter_timing_unit_pkg::CMD_DISARM_BIT])
				begin
					armed[n] <= 1'b0;
					started <= 1'b0;
				end
				else
				begin
					if (wr_here && paddr_in[3:2] == multi_counter_timing_unit_pkg::CTR_CMD_WORD
						&& pwdata_in[multi_counter_timing_unit_pkg::CMD_ARM_BIT])
						armed[n] <= 1'b1;
					if (armed[n] && ((gmode == multi_counter_timing_unit_pkg::GATE_RISE && gate_rise[n])
						|| (gmode == multi_counter_timing_unit_pkg::GATE_FALL && gate_fall[n])))
						started <= 1'b1;
				end
			end
			always_ff @(posedge sys_clk_in)
			begin
				if (!nrst_in)
					count_q[n] <= 16'h0000;
				else if (wr_here && paddr_in[3:2] == multi_counter_timing_unit_pkg::CTR_CMD_WORD
					&& pwdata_in[multi_counter_timing_unit_pkg::CMD_LOAD_BIT])
					count_q[n] <= hold_q[n];
				else if (tc_ev[n] && mode_q[n][multi_counter_timing_unit_pkg::MODE_RELOAD_BIT])
					count_q[n] <= hold_q[n];
				else if (cnt_ev[n])
					count_q[n] <= stepped;
			end
			always_ff @(posedge sys_clk_in)
			begin
				if (!nrst_in)
					out_true[n] <= 1'b0;
				else if (cnt_ev[n])
				begin
					if (mode_q[n][multi_counter_timing_unit_pkg::MODE_TOGGLE_BIT])
						out_true[n] <= out_true[n] ^ at_tc;
					else
						out_true[n] <= at_tc;
				end
			end
			assign out_lg[n] = out_true[n] ^ mode_q[n][multi_counter_timing_unit_pkg::MODE_INVERT_BIT];
			always_ff @(posedge sys_clk_in)
			begin
				if (!nrst_in)
				begin
					counter_out_out[n] <= 1'b0;
					counter_oe_out[n] <= 1'b0;
				end
				else
				begin
					case (mode_q[n][multi_counter_timing_unit_pkg::MODE_OUT_LSB +: 2])
						multi_counter_timing_unit_pkg::OUT_ACTIVE:
						begin
							counter_out_out[n] <= out_lg[n];
							counter_oe_out[n] <= 1'b1;
						end
						multi_counter_timing_unit_pkg::OUT_LOW:
						begin
							counter_out_out[n] <= 1'b0;
							counter_oe_out[n] <= 1'b1;
						end
						default:
						begin
							counter_out_out[n] <= 1'b0;
							counter_oe_out[n] <= 1'b0;
						end
					endcase
				end
			end
		end
	endgenerate
	// ****************************************
	// Glue outputs and frequency divider
	// ****************************************
	logic [3:0] fcnt;
	logic [14:0] fsrc_v;
	logic fev;
	assign fsrc_v = {src_rise, gate_rise, tb_ev};
	assign fev = freq_q[multi_counter_timing_unit_pkg::FREQ_EN_BIT]
		&& (freq_q[multi_counter_timing_unit_pkg::FREQ_SRC_LSB +: 4] <= multi_counter_timing_unit_pkg::FREQ_SRC_LAST)
		&& fsrc_v[freq_q[multi_counter_timing_unit_pkg::FREQ_SRC_LSB +: 4]];
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			fcnt <= 4'h0;
			divided_frequency_output_q <= 1'b0;
		end
		else if (!freq_q[multi_counter_timing_unit_pkg::FREQ_EN_BIT])
		begin
			fcnt <= 4'h0;
			divided_frequency_output_q <= 1'b0;
		end
		else if (fev)
		begin
			// A divider of zero counts sixteen through the 4-bit wrap
			if (fcnt == 4'(freq_q[multi_counter_timing_unit_pkg::FREQ_DIV_LSB +: 4] - 4'h1))
			begin
				fcnt <= 4'h0;
				divided_frequency_output_q <= 1'b1;
			end
			else
			begin
				fcnt <= 4'(fcnt + 4'h1);
				divided_frequency_output_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			out_prev <= 5'h00;
			divided_frequency_output_out <= 1'b0;
			third_counter_output_out <= 1'b0;
			fourth_counter_output_out <= 1'b0;
			second_counter_output_out <= 1'b0;
			fourth_counter_gate_out <= 1'b0;
			dac_update_out <= 1'b0;
			counter_irq_req_out <= 1'b0;
		end
		else
		begin
			out_prev <= out_lg;
			divided_frequency_output_out <= divided_frequency_output_q;
			third_counter_output_out <= out_lg[2];
			fourth_counter_output_out <= out_lg[3];
			second_counter_output_out <= out_lg[1];
			fourth_counter_gate_out <= fourth_counter_gate_q;
			dac_update_out <= board_q[multi_counter_timing_unit_pkg::BOARD_DEFER_BIT] && out_fall[1];
			counter_irq_req_out <= board_q[multi_counter_timing_unit_pkg::BOARD_IRQ_EN_BIT] && out_rise[1];
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	sequence s_quiet3;
		!int_tick [*3];
	endsequence
	property p_master_div;
		@(posedge sys_clk_in) disable iff (!nrst_in) int_tick |=> s_quiet3 ##1 int_tick;
	endproperty
	a_master_div: assert property (p_master_div) else $error("internal master tick period wrong");
	property p_decade;
		@(posedge sys_clk_in) disable iff (!nrst_in) tb_ev[1] |-> tb_ev[0] && dec_cnt[1] == 4'h9;
	endproperty
	a_decade: assert property (p_decade) else $error("timebase not a decade of previous");
	property p_fourth_counter_gate_set;
		@(posedge sys_clk_in) disable iff (!nrst_in) stop_rise |=> fourth_counter_gate_q ##1 fourth_counter_gate_out;
	endproperty
	a_fourth_counter_gate_set: assert property (p_fourth_counter_gate_set) else $error("stop trigger did not set gate");
	property p_fourth_counter_gate_clr;
		@(posedge sys_clk_in) disable iff (!nrst_in)
			(acq_overflow_in || sample_count_done_in) && !stop_rise |=> !fourth_counter_gate_q;
	endproperty
	a_fourth_counter_gate_clr: assert property (p_fourth_counter_gate_clr) else $error("gate flip-flop not cleared");
	property p_irq;
		@(posedge sys_clk_in) disable iff (!nrst_in)
			$rose(out_lg[1]) |-> ##1 (counter_irq_req_out == $past(board_q[3]));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt request mismatch");
	property p_dac;
		@(posedge sys_clk_in) disable iff (!nrst_in) dac_update_out |-> $past(board_q[4]) && !out_prev[1];
	endproperty
	a_dac: assert property (p_dac) else $error("converter update without low edge");
	property p_step;
		@(posedge sys_clk_in) disable iff (!nrst_in)
			cnt_ev[0] && !tc_ev[0] && !mode_q[0][8] && !wr_en |=> count_q[0] == 16'($past(count_q[0]) + 16'h0001);
	endproperty
	a_step: assert property (p_step) else $error("up count step wrong");
	property p_pulse;
		@(posedge sys_clk_in) disable iff (!nrst_in)
			tc_ev[0] && !mode_q[0][10] |=> out_true[0] ##1 (counter_out_out[0] || mode_q[0][13:12] != 2'h0 || mode_q[0][11]);
	endproperty
	a_pulse: assert property (p_pulse) else $error("terminal count pulse missing");
	property p_toggle;
		@(posedge sys_clk_in) disable iff (!nrst_in)
			tc_ev[1] && mode_q[1][10] |=> out_true[1] != $past(out_true[1]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle output did not invert");
	property p_hiz;
		@(posedge sys_clk_in) disable iff (!nrst_in)
			mode_q[0][13:12] == 2'h1 [*2] |-> !counter_oe_out[0] && !counter_out_out[0];
	endproperty
	a_hiz: assert property (p_hiz) else $error("output driven while high impedance");
endmodule
`default_nettype wire

// ### tb/field_signal_model.sv
// Field pin model: counter source, gate and stop-trigger pins.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module field_signal_model (
	input wire logic clk_in,
	output var logic [4:0] gate_pin_out,
	output var logic [4:0] source_pin_out,
	output var logic stop_trigger_out
);
	// ********************
	// Pin drivers
	// ********************
	initial
	begin
		gate_pin_out = 5'h1F;
		source_pin_out = 5'h00;
		stop_trigger_out = 1'h0;
	end
	// Ten cycles a level, well past the pin sync delay
	task automatic set_src(input logic v);
		source_pin_out <= {5{v}};
		repeat (10) @(posedge clk_in);
	endtask
	task automatic set_gate(input logic [4:0] v);
		gate_pin_out <= v;
		repeat (10) @(posedge clk_in);
	endtask
	task automatic burst(input int n);
		repeat (n)
		begin
			set_src(1'h1);
			set_src(1'h0);
		end
	endtask
	task automatic stop_pulse;
		stop_trigger_out <= 1'h1;
		repeat (10) @(posedge clk_in);
		stop_trigger_out <= 1'h0;
		repeat (10) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Bench: APB tasks and field pin model drive the counter unit.
// Assumes the hand-over register map and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %0h", $time, a); end end
module tb_top;
	logic sys_clk_in = 1'h0;
	logic nrst_in = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rv;
	logic pready, pslverr, err, second_counter_output, fourth_counter_gate, irq, dac, stop_pin, divided_frequency_output;
	logic irq_seen = 1'h0, dac_seen = 1'h0;
	logic [2:0] clr = 3'h0;
	logic [4:0] gate_pins, src_pins, cnt_out, cnt_oe;
	logic third_counter_output, fourth_counter_output, g3 = 1'h0, scan = 1'h0;
	logic [6:0] trig = 7'h00;
	logic [4:0] gate_a, gate_b;
	int fails = 0, checks_done = 0, cyc = 0;
	always #12.5 sys_clk_in = ~sys_clk_in;
	field_signal_model fld (.clk_in(sys_clk_in), .gate_pin_out(gate_pins), .source_pin_out(src_pins),
		.stop_trigger_out(stop_pin));
	multi_counter_timing_unit uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .board_master_clock_in(1'h0), .clock_select_jumper_in(1'h0),
		.gate_pin_in(gate_pins), .source_pin_in(src_pins), .stop_trigger_input_in(stop_pin),
		.trigger_crossbar_bus_in(trig), .scan_step_clock_in(scan), .acq_third_gate_in(g3),
		.sample_count_done_in(clr[0]), .acq_overflow_in(clr[1]), .acq_overrun_in(clr[2]),
		.counter_out_out(cnt_out), .counter_oe_out(cnt_oe), .divided_frequency_output_out(divided_frequency_output),
		.third_counter_output_out(third_counter_output), .fourth_counter_output_out(fourth_counter_output), .second_counter_output_out(second_counter_output),
		.fourth_counter_gate_out(fourth_counter_gate), .dac_update_out(dac), .counter_irq_req_out(irq));
	// Pulses last one cycle, so latch them
	always @(posedge sys_clk_in)
	begin
		cyc <= cyc + 1;
		if (irq === 1'h1)
			irq_seen <= 1'h1;
		if (dac === 1'h1)
			dac_seen <= 1'h1;
		if (cyc == 20000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1'h1;
		do
			@(posedge sys_clk_in);
		while (pready !== 1'h1);
		rv = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h00000000);
		`CHK(rv, e)
	endtask
	// Disarm first so a stale start flag is dropped
	task automatic setup(input logic [7:0] b, input logic [15:0] mode, input logic [15:0] hold);
		apb(1'h1, b + 8'h0C, 32'h00000002);
		apb(1'h1, b, {16'h0000, mode});
		apb(1'h1, b + 8'h04, {16'h0000, hold});
		apb(1'h1, b + 8'h0C, 32'h00000005);
	endtask
	// Scan clock and trigger line five, ten cycles a level
	task automatic pins(input int n);
		repeat (n)
		begin
			scan <= 1'h1;
			trig <= 7'h20;
			repeat (10) @(posedge sys_clk_in);
			scan <= 1'h0;
			trig <= 7'h00;
			repeat (10) @(posedge sys_clk_in);
		end
	endtask
	// ********************
	// Scenarios
	// ********************
	initial
	begin
		repeat (6) @(posedge sys_clk_in);
		nrst_in <= 1'h1;
		rd_chk(8'h00, 32'h00001000);
		`CHK(cnt_oe, 5'h00)
		rd_chk(8'h60, 32'h00000000);
		`CHK(err, 1'h1)
		setup(8'h00, 16'h060A, 16'hFFFE);
		setup(8'h10, 16'h060A, 16'hFFFE);
		apb(1'h1, 8'h54, 32'h00000018);
		rd_chk(8'h08, 32'h0000FFFE);
		fld.burst(2);
		rd_chk(8'h08, 32'h0000FFFE);
		`CHK({cnt_oe[0], cnt_out[0], second_counter_output, irq_seen, dac_seen}, 5'h1E)
		fld.burst(2);
		`CHK({cnt_out[0], second_counter_output, dac_seen}, 3'h1)
		apb(1'h1, 8'h00, 32'h00000E0A);
		repeat (3) @(posedge sys_clk_in);
		`CHK(cnt_out[0], 1'h1)
		apb(1'h1, 8'h00, 32'h00002E0A);
		repeat (3) @(posedge sys_clk_in);
		`CHK({cnt_oe[0], cnt_out[0]}, 2'h2)
		setup(8'h00, 16'h001A, 16'h0000);
		fld.set_src(1'h1);
		rd_chk(8'h08, 32'h00000000);
		fld.set_src(1'h0);
		rd_chk(8'h08, 32'h00000001);
		for (int g = 1; g < 7; g++)
		begin
			gate_a = (g == 2 || g == 4) ? 5'h1F : ((g > 4) ? 5'h01 : 5'h00);
			gate_b = (g == 5) ? 5'h02 : ((g == 6) ? 5'h10 : ~gate_a);
			setup(8'h00, 16'h000A | 16'(g << 5), 16'h0000);
			fld.set_gate(gate_a);
			fld.burst(1);
			rd_chk(8'h08, 32'h00000000);
			fld.set_gate(gate_b);
			fld.burst(1);
			rd_chk(8'h08, 32'h00000001);
		end
		setup(8'h00, 16'h020A, 16'hFFFE);
		fld.burst(2);
		`CHK(cnt_out[0], 1'h1)
		fld.burst(1);
		`CHK(cnt_out[0], 1'h0)
		apb(1'h1, 8'h54, 32'h00000025);
		setup(8'h20, 16'h022C, 16'hFFFE);
		setup(8'h30, 16'h020E, 16'hFFFF);
		setup(8'h40, 16'h0000, 16'h0000);
		pins(1);
		rd_chk(8'h28, 32'h0000FFFE);
		g3 <= 1'h1;
		pins(2);
		`CHK({third_counter_output, fourth_counter_output}, 2'h3)
		rd_chk(8'h48, 32'h00000003);
		apb(1'h1, 8'h50, 32'h0000011A);
		fld.burst(2);
		`CHK(divided_frequency_output, 1'h1)
		apb(1'h1, 8'h50, 32'h0000013A);
		fld.burst(2);
		`CHK(divided_frequency_output, 1'h0)
		fld.burst(1);
		`CHK(divided_frequency_output, 1'h1)
		for (int i = 0; i < 4; i++)
		begin
			fld.stop_pulse();
			`CHK(fourth_counter_gate, 1'h1)
			if (i < 3)
				clr <= 3'(1 << i);
			else
				apb(1'h1, 8'h58, 32'h00000001);
			@(posedge sys_clk_in);
			clr <= 3'h0;
			repeat (3) @(posedge sys_clk_in);
			`CHK(fourth_counter_gate, 1'h0)
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
